// [pswitch_ctrl.sv]
// 1+1 protection switch control with serial terminal and register bus
`timescale 1ns/1ps
// How it works
// - five panel buttons: auto and four forces
// - red light per active transceiver alarm
// - green relay lights, flashing while overridden
// - unresolved relay position lights both greens
// - switch fault light on relay/cable/internal fault
// - auto button puts both channels automatic
// - automatic picks the transceiver without alarm
// - no alarm keeps selection, alarm switches
// - transmit and receive selections independent
// - force selects side until auto/opposite
// - non-revertive after alarm clears
// - back to auto keeps forced side
// - one channel auto, other overridden
// - serial default 1200 baud 8N1
// - periodic screen, settable seconds, zero disables
// - five line status screen plus prompt
// - two ports, terminal or packet mode
// - echo received characters when enabled
// - line feed after carriage return option
// - new rate applied after accepted command
// - serial auto command equals auto button
// - serial force commands equal force buttons
// - alarm A sets toward B, B toward A
// - open alarm contact means active alarm
// - position feedback mismatch raises switch fault
module pswitch_ctrl
  import pswitch_pkg::*;
#(
  parameter logic [SEC_W-1:0] SEC_CYC = SEC_W'(SEC_CYC_DEF),
  parameter logic [FLASH_W-1:0] FLASH_CYC = FLASH_W'(FLASH_CYC_DEF),
  parameter logic [DIV_W-1:0] BAUD_DIV = DIV_W'(BAUD_DIV_DEF),
  // arbitrary identity characters
  parameter logic [7:0] REV_CHAR = 8'h30,
  parameter logic [7:0] SERIAL_CHAR = 8'h30
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // panel and field contacts, 1 = pressed / closed
  input wire panel_btn_type btn,
  input wire logic [3:0] alarm_contact_closed,
  input wire logic [3:0] relay_pos_closed,
  // serial ports
  input wire logic rs232_rxd,
  input wire logic rs485_rxd,
  output logic rs232_txd,
  output logic rs485_txd,
  output logic rs485_drive_en,
  // lamps and relay drive
  output led_type led,
  output logic [1:0] relay_sel_b
);
  state_type s;
  state_type n;
  logic [4:0] btn_now;
  logic [4:0] ev;
  logic [4:0] ser_cmd;
  logic pick_ok;
  logic [7:0] pick;
  logic ascii;

  function automatic logic [4:0] cmd_decode(input logic [7:0] c);
    case (c)
      auto_mode_cmd: cmd_decode = 5'h01;
      force_transmit_side_a_cmd: cmd_decode = 5'h02;
      force_transmit_side_b_cmd: cmd_decode = 5'h04;
      force_receive_side_a_cmd: cmd_decode = 5'h08;
      force_receive_side_b_cmd: cmd_decode = 5'h10;
      default: cmd_decode = 5'h00;
    endcase
  endfunction

  function automatic logic [7:0] bit_ch(input logic b);
    bit_ch = CH_ZERO | {7'h00, b};
  endfunction

  // A/B side letter, B when the bit is set
  function automatic logic [7:0] ab_ch(input logic b);
    ab_ch = b ? 8'h42 : 8'h41;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    merge = r;
  endfunction

  // status screen, one character per index
  function automatic logic [7:0] screen_char(input logic [4:0] i,
      input state_type st);
    case (i)
      5'h00: screen_char = 8'h50;
      5'h01: screen_char = 8'h53;
      5'h02: screen_char = 8'h52;
      5'h03: screen_char = REV_CHAR;
      5'h04: screen_char = 8'h4e;
      5'h05: screen_char = SERIAL_CHAR;
      5'h07: screen_char = 8'h41;
      5'h08: screen_char = bit_ch(st.alarm[0]);
      5'h09: screen_char = bit_ch(st.alarm[1]);
      5'h0a: screen_char = bit_ch(st.alarm[2]);
      5'h0b: screen_char = bit_ch(st.alarm[3]);
      5'h0c: screen_char = bit_ch(st.led.switch_fault);
      5'h0e: screen_char = 8'h54;
      5'h0f: screen_char = ab_ch(st.sel_b[0]);
      5'h10: screen_char = st.ovr[0] ? 8'h4d : 8'h41;
      5'h12: screen_char = 8'h52;
      5'h13: screen_char = ab_ch(st.sel_b[1]);
      5'h14: screen_char = st.ovr[1] ? 8'h4d : 8'h41;
      5'h16: screen_char = st.cfg[CFG_PORT] ? 8'h34 : 8'h32;
      5'h17: screen_char = st.cfg[CFG_PKT] ? 8'h4b : 8'h41;
      5'h18: screen_char = bit_ch(st.cfg[CFG_ECHO]);
      5'h19: screen_char = bit_ch(st.cfg[line_feed_after_return]);
      5'h1b: screen_char = 8'h3e;
      default: screen_char = CH_CR;
    endcase
  endfunction

  // a level counts once stages two and three agree
  assign btn_now = (s.btn_sync[2] & ~(s.btn_sync[1] ^ s.btn_sync[2]))
    | (s.btn_lvl & (s.btn_sync[1] ^ s.btn_sync[2]));
  assign ser_cmd = s.rx_done ? cmd_decode(s.rx_byte) : 5'h00;
  // button edge, serial command and register command act alike
  assign ev = (btn_now & ~s.btn_lvl) | ser_cmd | s.cmd_pulse;
  assign ascii = s.cfg[CFG_PKT] == ascii_terminal_mode;
  // transmit source priority: pending lf, echo, then screen
  assign pick_ok = s.lf_pend | s.echo_pend | s.scr_on;
  assign pick = s.lf_pend ? CH_LF
    : s.echo_pend ? s.echo_byte : screen_char(s.scr_idx, s);

  always_comb begin
    logic pa;
    logic pb;
    logic blink;
    logic [DIV_W-1:0] div_now;
    logic p;
    logic [31:0] wv;
    status_type stv;
    pa = 1'b0;
    pb = 1'b0;
    blink = 1'b0;
    div_now = s.div;
    p = s.cfg[CFG_PORT];
    wv = '0;
    stv = '0;
    n = s;
    // input synchronisers
    n.btn_sync = {s.btn_sync[1], s.btn_sync[0], btn};
    n.btn_lvl = btn_now;
    n.alm_sync = {s.alm_sync[1], s.alm_sync[0], ~alarm_contact_closed};
    n.alarm = (s.alm_sync[2] & ~(s.alm_sync[1] ^ s.alm_sync[2]))
      | (s.alarm & (s.alm_sync[1] ^ s.alm_sync[2]));
    n.fb_sync = {s.fb_sync[1], s.fb_sync[0], relay_pos_closed};
    n.fb = (s.fb_sync[2] & ~(s.fb_sync[1] ^ s.fb_sync[2]))
      | (s.fb & (s.fb_sync[1] ^ s.fb_sync[2]));
    n.rxd_sync = {s.rxd_sync[1], s.rxd_sync[0], {rs485_rxd, rs232_rxd}};
    if (s.rxd_sync[1][p] == s.rxd_sync[2][p]) n.rxd = s.rxd_sync[2][p];
    // lamp flash phase
    if (s.flash_cnt == FLASH_CYC - FLASH_W'(1)) begin
      n.flash_cnt = '0;
      n.flash_on = ~s.flash_on;
    end else begin
      n.flash_cnt = s.flash_cnt + FLASH_W'(1);
    end
    // each channel keeps its own latch and mode
    n.led.switch_fault = s.internal_fault;
    for (int c = 0; c < 2; c++) begin
      if (ev[1 + 2 * c]) begin
        n.sel_b[c] = 1'b0;
        n.ovr[c] = 1'b1;
      end else if (ev[2 + 2 * c]) begin
        n.sel_b[c] = 1'b1;
        n.ovr[c] = 1'b1;
      end else if (ev[CMD_AUTO]) begin
        n.ovr[c] = 1'b0;
      end
      // latch moves only on a one-sided alarm, never back on clear
      if (!n.ovr[c]) begin
        if (s.alarm[2 * c] && !s.alarm[2 * c + 1]) n.sel_b[c] = 1'b1;
        else if (s.alarm[2 * c + 1] && !s.alarm[2 * c]) n.sel_b[c] = 1'b0;
      end // both alarmed: hold
      pa = s.fb[2 * c];
      pb = s.fb[2 * c + 1];
      blink = ~s.ovr[c] | s.flash_on;
      n.unres[c] = pa == pb;
      n.led.online[2 * c] = (pa == pb) | (pa & blink);
      n.led.online[2 * c + 1] = (pa == pb) | (pb & blink);
      if (pa == pb || pb != s.sel_b[c]) n.led.switch_fault = 1'b1;
    end
    n.led.alarm = s.alarm;
    // periodic status screen
    if (s.sec_cnt == SEC_CYC - SEC_W'(1)) begin
      n.sec_cnt = '0;
      n.secs = s.secs + 16'h0001;
    end else begin
      n.sec_cnt = s.sec_cnt + SEC_W'(1);
    end
    if (s.refresh == 16'h0000) begin
      n.secs = '0;
    end else if (s.secs >= s.refresh) begin
      n.secs = '0;
      if (ascii && !s.scr_on) begin
        n.scr_on = 1'b1;
        n.scr_idx = '0;
      end
    end
    // new rate only while both serial engines are idle
    if (s.tx_st == TX_IDLE && s.rx_st == RX_IDLE) div_now = s.baud;
    n.div = div_now;
    // transmitter, 8 data bits, no parity, one stop bit
    unique case (s.tx_st)
      TX_IDLE: begin
        if (pick_ok) begin
          n.tx_sh = pick;
          n.tx_st = TX_START;
          n.tx_cnt = div_now - DIV_W'(1);
          if (s.lf_pend) n.lf_pend = 1'b0;
          else if (s.echo_pend) n.echo_pend = 1'b0;
          else if (s.scr_idx == SCR_LAST) n.scr_on = 1'b0;
          else n.scr_idx = s.scr_idx + 5'h01;
          if (pick == CH_CR && s.cfg[line_feed_after_return])
            n.lf_pend = 1'b1;
        end
      end
      TX_START, TX_DATA, TX_STOP: begin
        if (s.tx_cnt != '0) begin
          n.tx_cnt = s.tx_cnt - DIV_W'(1);
        end else begin
          n.tx_cnt = s.div - DIV_W'(1);
          if (s.tx_st == TX_START) begin
            n.tx_st = TX_DATA;
            n.tx_bit = '0;
          end else if (s.tx_st == TX_STOP) begin
            n.tx_st = TX_IDLE;
          end else begin
            n.tx_sh = {1'b1, s.tx_sh[7:1]};
            n.tx_bit = s.tx_bit + 3'h1;
            if (s.tx_bit == 3'h7) n.tx_st = TX_STOP;
          end
        end
      end
      default: begin
        // illegal code is a controller fault
        n.internal_fault = 1'b1;
        n.tx_st = TX_IDLE;
      end
    endcase
    n.tx232 = 1'b1;
    n.tx485 = 1'b1;
    if (n.tx_st == TX_START) n.tx232 = 1'b0;
    if (n.tx_st == TX_DATA) n.tx232 = n.tx_sh[0];
    if (p == rs485_port_id) begin
      n.tx485 = n.tx232;
      n.tx232 = 1'b1;
    end
    n.de485 = (p == rs485_port_id) && n.tx_st != TX_IDLE;
    // receiver, sampled mid bit
    n.rx_done = 1'b0;
    unique case (s.rx_st)
      RX_IDLE: begin
        if (!s.rxd) begin
          n.rx_st = RX_START;
          n.rx_cnt = {1'b0, div_now[DIV_W-1:1]};
        end
      end
      RX_START, RX_DATA, RX_STOP: begin
        if (s.rx_cnt != '0) begin
          n.rx_cnt = s.rx_cnt - DIV_W'(1);
        end else begin
          n.rx_cnt = s.div - DIV_W'(1);
          if (s.rx_st == RX_START) begin
            n.rx_st = s.rxd ? RX_IDLE : RX_DATA;
            n.rx_bit = '0;
          end else if (s.rx_st == RX_DATA) begin
            n.rx_sh = {s.rxd, s.rx_sh[7:1]};
            n.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == 3'h7) n.rx_st = RX_STOP;
          end else begin
            n.rx_st = RX_IDLE;
            n.rx_done = s.rxd; // framing error drops the byte
            n.rx_byte = s.rx_sh;
          end
        end
      end
      default: begin
        n.internal_fault = 1'b1;
        n.rx_st = RX_IDLE;
      end
    endcase
    // one pending echo; a second byte in its wait is not echoed
    if (s.rx_done && s.cfg[CFG_ECHO] && ascii && !s.echo_pend) begin
      n.echo_pend = 1'b1;
      n.echo_byte = s.rx_byte;
    end
    // axi4-lite write channel
    n.cmd_pulse = '0;
    if (s.bvalid && bready) n.bvalid = 1'b0;
    if (awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case ({s.awaddr[7:2], 2'b00})
        CMD_OFS: if (s.wstrb[0]) n.cmd_pulse = s.wdata[4:0];
        CFG_OFS: if (s.wstrb[0]) n.cfg = s.wdata[3:0];
        REFRESH_OFS: begin
          wv = merge({16'h0000, s.refresh}, s.wdata, s.wstrb);
          n.refresh = wv[15:0];
        end
        BAUD_OFS: begin
          wv = merge({12'h000, s.baud}, s.wdata, s.wstrb);
          if (wv[DIV_W-1:0] < BAUD_DIV_MIN) n.bresp = RESP_SLVERR;
          else n.baud = wv[DIV_W-1:0];
        end
        STATUS_OFS: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_DECERR;
      endcase
    end
    n.awready = ~n.aw_got;
    n.wready = ~n.w_got;
    // axi4-lite read channel
    if (s.rvalid && rready) n.rvalid = 1'b0;
    if (arvalid && s.arready) begin
      stv.alarm = s.alarm;
      stv.sel_b = s.sel_b;
      stv.ovr = s.ovr;
      stv.fault = s.led.switch_fault;
      stv.unresolved = s.unres;
      stv.internal_fault = s.internal_fault;
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      unique case ({araddr[7:2], 2'b00})
        CMD_OFS: n.rdata = '0;
        CFG_OFS: n.rdata = {28'h0000000, s.cfg};
        REFRESH_OFS: n.rdata = {16'h0000, s.refresh};
        BAUD_OFS: n.rdata = {12'h000, s.baud};
        STATUS_OFS: n.rdata = stv;
        default: begin
          n.rdata = '0;
          n.rresp = RESP_DECERR;
        end
      endcase
    end
    n.arready = ~n.rvalid;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.rxd_sync <= 6'h3f;
      s.rxd <= 1'b1;
      s.cfg <= CFG_RESET;
      s.refresh <= REFRESH_S_DEF;
      s.baud <= BAUD_DIV;
      s.div <= BAUD_DIV;
      s.tx_st <= TX_IDLE;
      s.rx_st <= RX_IDLE;
      s.tx232 <= 1'b1;
      s.tx485 <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign rs232_txd = s.tx232;
  assign rs485_txd = s.tx485;
  assign rs485_drive_en = s.de485;
  assign led = s.led;
  assign relay_sel_b = s.sel_b;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence cr_start;
    s.tx_st == TX_IDLE && pick_ok && pick == CH_CR;
  endsequence
  sequence echo_taken;
    s.rx_done && s.cfg[CFG_ECHO] && ascii && !s.echo_pend;
  endsequence

  auto_clears_ovr_a: assert property (
    ev[0] && ev[4:1] == 4'h0 |=> s.ovr == 2'b00)
    else $error("auto did not clear override");
  force_tx_a_a: assert property (
    ev[1] |=> s.ovr[0] && !s.sel_b[0] && relay_sel_b[0] == 1'b0)
    else $error("force transmit A not applied");
  force_rx_b_a: assert property (
    ev[4] && !ev[3] |=> s.ovr[1] && s.sel_b[1])
    else $error("force receive B not applied");
  alarm_moves_a: assert property (
    !s.ovr[0] && ev == 5'h00 && s.alarm[0] && !s.alarm[1] |=> s.sel_b[0])
    else $error("alarm on A did not select B");
  dual_alarm_hold_a: assert property (
    !s.ovr[1] && ev == 5'h00 && s.alarm[3:2] == 2'b11
    |=> $stable(s.sel_b[1]))
    else $error("both alarms changed selection");
  override_holds_a: assert property (
    s.ovr[0] && ev == 5'h00 |=> $stable(s.sel_b[0]))
    else $error("override selection moved");
  red_led_a: assert property (
    $changed(s.alarm) |=> led.alarm == $past(s.alarm))
    else $error("red lamps do not follow alarms");
  unresolved_both_a: assert property (
    s.fb[0] == s.fb[1] |=> led.online[1:0] == 2'b11 && led.switch_fault)
    else $error("unresolved relay not shown");
  mismatch_fault_a: assert property (
    s.fb[2] != s.fb[3] && s.fb[3] != s.sel_b[1] |=> led.switch_fault)
    else $error("position mismatch without fault");
  echo_queued_a: assert property (
    echo_taken |=> s.echo_pend && s.echo_byte == $past(s.rx_byte))
    else $error("received byte not queued for echo");
  lf_follows_cr_a: assert property (
    cr_start |=> s.lf_pend == $past(s.cfg[line_feed_after_return]))
    else $error("line feed setting not honoured");
  start_bit_a: assert property (
    s.tx_st == TX_IDLE && pick_ok |=> s.tx_st == TX_START
    ##1 !(rs232_txd && rs485_txd))
    else $error("start bit missing");
endmodule

// [pswitch_ctrl_tb_top.sv]
// self-checking bench for the protection switch control
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module pswitch_ctrl_tb_top;
  import pswitch_pkg::*;
  logic clk_sys, arst_n, awvalid, wvalid, bready, arvalid, rready, rs232_rxd;
  logic awready, wready, bvalid, arready, rvalid, rs232_txd;
  logic rs485_txd, rs485_drive_en, rs485_rxd;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, alarm_on, alarm_contact_closed, relay_pos_closed;
  logic [1:0] bresp, rresp, relay_sel_b, cut, r, s;
  panel_btn_type btn;
  led_type led;
  int err_total, compares;
  // short counts keep the run brief
  pswitch_ctrl #(.SEC_CYC(27'h64), .FLASH_CYC(25'h8), .BAUD_DIV(20'h10)) dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .btn(btn), .alarm_contact_closed(alarm_contact_closed),
    .relay_pos_closed(relay_pos_closed), .rs232_rxd(rs232_rxd),
    .rs485_rxd(rs485_rxd), .rs232_txd(rs232_txd), .rs485_txd(rs485_txd),
    .rs485_drive_en(rs485_drive_en), .led(led), .relay_sel_b(relay_sel_b));
  pswitch_partner far_u (.alarm_on(alarm_on), .cut(cut),
    .relay_sel_b(relay_sel_b), .alarm_contact_closed(alarm_contact_closed),
    .relay_pos_closed(relay_pos_closed));
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  task summarize();
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // input sync, latch, relay feedback sync and lamps must all move
  task settle();
    repeat (12) @(posedge clk_sys);
  endtask
  // axi4-lite write, address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    awvalid <= 1'h1; awaddr <= a; wvalid <= 1'h1; wdata <= v;
    for (n = 0; n < 60; n++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) break;
    end
    rs = bresp;
    if (n == 60) begin err_total++; summarize(); end
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    arvalid <= 1'h1; araddr <= a;
    for (n = 0; n < 60; n++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) break;
    end
    v = rdata; rs = rresp;
    if (n == 60) begin err_total++; summarize(); end
  endtask
  // momentary panel press, long enough to pass the synchroniser
  task press(input logic [4:0] b);
    btn <= b;
    repeat (6) @(posedge clk_sys);
    btn <= '0;
    settle();
  endtask
  // terminal side: 8N1, lsb first, 16 clocks per bit, on port p
  task ser(input logic [7:0] c, input logic p);
    logic [9:0] f;
    f = {1'h1, c, 1'h0};
    for (int i = 0; i < 10; i++) begin
      if (p) rs485_rxd <= f[i];
      else rs232_rxd <= f[i];
      repeat (16) @(posedge clk_sys);
    end
    repeat (24) @(posedge clk_sys);
  endtask
  // terminal receiver: waits for a start bit, samples each bit mid way
  task get(output logic [7:0] c, input logic p);
    int n;
    for (n = 0; n < 4000 && (p ? rs485_txd : rs232_txd); n++)
      @(posedge clk_sys);
    if (n == 4000) begin err_total++; summarize(); end
    repeat (8) @(posedge clk_sys);
    `CHK(rs485_drive_en, p)
    for (n = 0; n < 8; n++) begin
      repeat (16) @(posedge clk_sys);
      c[n] = p ? rs485_txd : rs232_txd;
    end
    repeat (16) @(posedge clk_sys);
    `CHK(p ? rs485_txd : rs232_txd, 1'h1)
  endtask
  // one typed character, its echo caught while it is sent
  task talk(input logic [7:0] c, input logic p);
    logic [7:0] e;
    fork
      ser(c, p);
      get(e, p);
    join
    `CHK(e, c)
  endtask
  // s[1] = lamp seen on, s[0] = lamp seen off over three flash periods
  task lamp(input int i);
    s = 2'h0;
    repeat (48) begin
      @(posedge clk_sys);
      s = s | {led.online[i], ~led.online[i]};
    end
  endtask
  task t_reset();
    settle();
    `CHK(relay_sel_b, 2'h0)
    rd(REFRESH_OFS, d, r); `CHK(d, 32'h1e)
    rd(BAUD_OFS, d, r); `CHK(d, 32'h10)
    rd(CFG_OFS, d, r); `CHK(d, 32'h1)
    rd(8'h20, d, r); `CHK(r, RESP_DECERR)
    wr(REFRESH_OFS, 32'h0, r); `CHK(r, RESP_OKAY)
    `CHK(led.switch_fault, 1'h0)
  endtask
  task t_auto();
    alarm_on <= 4'h1; settle();
    `CHK(relay_sel_b, 2'h1)
    `CHK(led.alarm, 4'h1)
    alarm_on <= 4'h0; settle(); `CHK(relay_sel_b, 2'h1)
    alarm_on <= 4'h3; settle(); `CHK(relay_sel_b, 2'h1)
    alarm_on <= 4'h2; settle(); `CHK(relay_sel_b, 2'h0)
    alarm_on <= 4'h4; settle(); `CHK(relay_sel_b, 2'h2)
    lamp(3); `CHK(s, 2'h2)
  endtask
  task t_force();
    alarm_on <= 4'h2; press(5'h04); `CHK(relay_sel_b, 2'h3)
    lamp(1); `CHK(s, 2'h3)
    alarm_on <= 4'ha; settle(); `CHK(relay_sel_b, 2'h1)
    press(5'h02); `CHK(relay_sel_b, 2'h0)
    alarm_on <= 4'h1; settle(); `CHK(relay_sel_b, 2'h0)
    press(5'h01); `CHK(relay_sel_b, 2'h1)
    rd(STATUS_OFS, d, r); `CHK(d[7:6], 2'h0)
    alarm_on <= 4'h0; press(5'h10); press(5'h01);
    `CHK(relay_sel_b, 2'h3)
  endtask
  task t_cmd();
    wr(CMD_OFS, 32'h8, r); settle(); `CHK(relay_sel_b, 2'h1)
    rd(STATUS_OFS, d, r); `CHK(d[7:6], 2'h2)
    talk(force_transmit_side_a_cmd, 1'h0); `CHK(relay_sel_b, 2'h0)
    talk(auto_mode_cmd, 1'h0); rd(STATUS_OFS, d, r);
    `CHK(d[7:6], 2'h0)
    wr(BAUD_OFS, 32'hf, r); `CHK(r, RESP_SLVERR)
    rd(BAUD_OFS, d, r); `CHK(d, 32'h10)
    // echo of a carriage return is followed by a line feed
    wr(CFG_OFS, 32'h3, r);
    fork
      ser(CH_CR, 1'h0);
      begin get(d[7:0], 1'h0); get(d[15:8], 1'h0); end
    join
    `CHK(d[15:0], {CH_LF, CH_CR})
    // packet mode: command taken, nothing echoed
    wr(CFG_OFS, 32'h9, r); s = 2'h0;
    fork
      ser(force_receive_side_b_cmd, 1'h0);
      repeat (200) begin
        @(posedge clk_sys);
        s[0] = s[0] | ~rs232_txd;
      end
    join
    `CHK(s[0], 1'h0)
    `CHK(relay_sel_b, 2'h2)
    wr(CFG_OFS, 32'h5, r); talk(8'h5a, 1'h1);
  endtask
  // screen comes back once a refresh interval is set
  task t_screen();
    wr(CFG_OFS, 32'h1, r); wr(REFRESH_OFS, 32'h1, r);
    get(d[7:0], 1'h0); `CHK(d[7:0], 8'h50)
  endtask
  task t_fault();
    cut <= 2'h1; settle();
    `CHK(led.online[1:0], 2'h3)
    `CHK(led.switch_fault, 1'h1)
    cut <= 2'h0; settle(); `CHK(led.switch_fault, 1'h0)
  endtask
  initial begin
    err_total = 0; compares = 0; arst_n = 1'h0; btn = '0; rs232_rxd = 1'h1;
    awvalid = 1'h0; wvalid = 1'h0; bready = 1'h1; arvalid = 1'h0;
    rready = 1'h1; awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0;
    wstrb = 4'hf; alarm_on = 4'h0; cut = 2'h0; rs485_rxd = 1'h1;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'h1;
    t_reset();
    t_auto();
    t_force();
    t_cmd();
    t_fault();
    t_screen();
    summarize();
  end
endmodule

// [pswitch_partner.sv]
// far side model: alarm contacts of both transceivers and latching relays
`timescale 1ns/1ps
module pswitch_partner (
  // stimulus from the bench
  input wire logic [3:0] alarm_on,
  input wire logic [1:0] cut,
  // relay drive from the controller
  input wire logic [1:0] relay_sel_b,
  // contacts seen by the controller
  output logic [3:0] alarm_contact_closed,
  output logic [3:0] relay_pos_closed
);
  // contact opens on alarm, so a dead unit reads as alarm
  assign alarm_contact_closed = ~alarm_on;
  // latching relay follows its drive; a cut cable opens both contacts
  always_comb begin
    relay_pos_closed[0] = ~cut[0] & ~relay_sel_b[0];
    relay_pos_closed[1] = ~cut[0] & relay_sel_b[0];
    relay_pos_closed[2] = ~cut[1] & ~relay_sel_b[1];
    relay_pos_closed[3] = ~cut[1] & relay_sel_b[1];
  end
endmodule

// [pswitch_pkg.sv]
// shared constants, types and state layout of the protection switch
package pswitch_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 1000;
  localparam int unsigned SEC_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned FLASH_CYC_DEF = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned BAUD_BPS_DEF = 1200;
  localparam int unsigned BAUD_DIV_DEF = CLK_HZ / BAUD_BPS_DEF;
  localparam int SEC_W = 27;
  localparam int FLASH_W = 25;
  localparam int DIV_W = 20;
  localparam logic [DIV_W-1:0] BAUD_DIV_MIN = 20'h00010;
  localparam logic [15:0] REFRESH_S_DEF = 16'h001e;
  // register offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] REFRESH_OFS = 8'h08;
  localparam logic [7:0] BAUD_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // command bits, also the event order
  localparam int CMD_AUTO = 0;
  // config bits
  localparam int CFG_ECHO = 0;
  localparam int line_feed_after_return = 1;
  localparam int CFG_PORT = 2;
  localparam int CFG_PKT = 3;
  localparam logic [3:0] CFG_RESET = 4'h1;
  localparam logic rs232_port_id = 1'h0;
  localparam logic rs485_port_id = 1'h1;
  localparam logic ascii_terminal_mode = 1'h0;
  // serial command characters
  localparam logic [7:0] auto_mode_cmd = 8'h41;
  localparam logic [7:0] force_transmit_side_a_cmd = 8'h31;
  localparam logic [7:0] force_transmit_side_b_cmd = 8'h32;
  localparam logic [7:0] force_receive_side_a_cmd = 8'h33;
  localparam logic [7:0] force_receive_side_b_cmd = 8'h34;
  // screen characters
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [4:0] SCR_LAST = 5'h1b;
  typedef enum logic [3:0] {TX_IDLE = 4'b0001, TX_START = 4'b0010,
    TX_DATA = 4'b0100, TX_STOP = 4'b1000} tx_state_type;
  typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_START = 4'b0010,
    RX_DATA = 4'b0100, RX_STOP = 4'b1000} rx_state_type;
  typedef struct packed {
    logic force_rx_b; logic force_rx_a; logic force_tx_b;
    logic force_tx_a; logic auto_mode;
  } panel_btn_type;
  typedef struct packed {
    logic [3:0] alarm; logic [3:0] online; logic switch_fault;
  } led_type;
  typedef struct packed {
    logic [19:0] zero; logic internal_fault; logic [1:0] unresolved;
    logic fault; logic [1:0] ovr; logic [1:0] sel_b; logic [3:0] alarm;
  } status_type;
  typedef struct packed {
    logic [2:0][4:0] btn_sync; logic [4:0] btn_lvl;
    logic [2:0][3:0] alm_sync; logic [3:0] alarm;
    logic [2:0][3:0] fb_sync; logic [3:0] fb;
    logic [2:0][1:0] rxd_sync; logic rxd;
    logic [1:0] sel_b; logic [1:0] ovr; logic [1:0] unres;
    logic [FLASH_W-1:0] flash_cnt; logic flash_on;
    led_type led; logic internal_fault;
    logic [3:0] cfg; logic [15:0] refresh;
    logic [DIV_W-1:0] baud; logic [DIV_W-1:0] div;
    logic [SEC_W-1:0] sec_cnt; logic [15:0] secs;
    logic scr_on; logic [4:0] scr_idx;
    tx_state_type tx_st; logic [DIV_W-1:0] tx_cnt;
    logic [2:0] tx_bit; logic [7:0] tx_sh;
    logic tx232; logic tx485; logic de485;
    logic lf_pend; logic echo_pend; logic [7:0] echo_byte;
    rx_state_type rx_st; logic [DIV_W-1:0] rx_cnt;
    logic [2:0] rx_bit; logic [7:0] rx_sh; logic rx_done; logic [7:0] rx_byte;
    logic aw_got; logic [7:0] awaddr; logic w_got;
    logic [31:0] wdata; logic [3:0] wstrb;
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    logic [4:0] cmd_pulse;
  } state_type;
endpackage
